// ===== scc_chk.sv
`timescale 1ns/1ps
module scc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] scl_h;
  logic       sda_h;
  logic [4:0] rise_cnt;
  logic       scl_rise;
  logic       fall_recent;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // late copies of the wire, so edges are seen as the target sees them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_h <= 4'hF;
      sda_h <= 1'b1;
    end else begin
      scl_h <= {scl_h[2:0], scl};
      sda_h <= sda;
    end
  end
  assign scl_rise    = scl && !scl_h[0];
  assign fall_recent = |(~scl_h[2:0] & scl_h[3:1]); // fell 1..3 edges ago

  // scl rises since the last start; saturates so long frames cannot wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 5'h00;
    end else if (scl && scl_h[0] && sda_h && !sda) begin
      rise_cnt <= 5'h00;
    end else if (scl_rise && rise_cnt != 5'h1F) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  sequence stop_s;
    scl && scl_h[0] && !sda_h && sda;
  endsequence
  sequence sda_moves_s;
    scl && scl_h[0] && (sda != sda_h);
  endsequence
  sequence ack_slot_s(logic [4:0] n);
    scl_rise && rise_cnt == n;
  endsequence

  // low phase must leave room for the target's two-clock answer
  AST_SCL_LOW: assert property (
    $rose(host_scl_oe) |=> host_scl_oe [*3])
    else $error("scl low phase too short");
  // target bit must already stand when scl rises
  AST_DEV_SETUP: assert property (
    scl_rise |-> $stable(dev_sda_oe))
    else $error("target sda moved at the scl rise");
  AST_DEV_HOLD: assert property (
    scl && scl_h[0] |-> $stable(dev_sda_oe))
    else $error("target moved sda while scl high");
  AST_DEV_ANSWER: assert property (
    $changed(dev_sda_oe) |-> !scl && fall_recent)
    else $error("target sda change not tied to a recent scl fall");
  AST_SCL_HIGH: assert property (
    $fell(host_scl_oe) |=> !host_scl_oe [*3])
    else $error("scl high phase too short");
  AST_FRAME_BY_HOST: assert property (
    sda_moves_s |-> $changed(host_sda_oe))
    else $error("start or stop not made by the host");
  AST_STOP_RELEASE: assert property (
    stop_s |-> !dev_sda_oe [*2])
    else $error("target holds sda across a stop");
  AST_ADDR_ACK: assert property (
    ack_slot_s(5'h08) |-> !sda && dev_sda_oe)
    else $error("address not acknowledged by the target");
  AST_INDEX_ACK: assert property (
    ack_slot_s(5'h11) |-> !sda)
    else $error("second byte of a frame not acknowledged");
endmodule // scc_chk

// ===== scc_host.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module scc_host #(
  parameter int DEPTH   = 8,
  parameter int QTR_CNT = scc_pkg::QTR_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  scc_smbus_if.host       bus,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic      [7:0] cmd_rdata
);
  import scc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  scc_hstage_t      stage;
  logic [1:0]       q;
  logic [3:0]       bit_i;
  logic [QTR_W-1:0] qtmr;
  logic             tick;
  logic [7:0]       rx_sh;
  logic [7:0]       ptr;
  logic [7:0]       idx;
  logic [7:0]       cnt;
  logic [7:0]       seen;
  logic [6:0]       taddr;
  logic             rd_dir;
  logic             err;
  logic             done;
  logic             scl_oe;
  logic             sda_oe;
  logic [7:0]       tx_byte;
  logic [7:0]       rd_val;
  logic             is_tx;
  logic             last;
  logic             drive_low;
  logic             in_buf;
  logic [7:0]       boff;
  logic [7:0]       buf_mem [DEPTH];

  assign in_buf = (cmd_addr >= HR_BUF) && (cmd_addr < HR_BUF + 8'(DEPTH));
  assign boff   = cmd_addr - HR_BUF;
  assign last   = (ptr == cnt - 8'h01);
  assign is_tx  = (stage == H_ADDR_W) || (stage == H_INDEX)
                  || (stage == H_COUNT) || (stage == H_WDATA)
                  || (stage == H_ADDR_R);

  // byte to send in each stage
  always_comb begin
    case (stage)
      H_ADDR_W: tx_byte = {taddr, 1'b0};
      H_INDEX:  tx_byte = idx;
      H_COUNT:  tx_byte = cnt;
      H_WDATA:  tx_byte = buf_mem[ptr[AW-1:0]];
      H_ADDR_R: tx_byte = {taddr, 1'b1};
      default:  tx_byte = IDLE_BYTE;
    endcase
  end

  // level placed on sda in the setup quarter of each bit
  always_comb begin
    if (bit_i != BIT_ACK) begin
      drive_low = is_tx & ~tx_byte[3'(BIT_LAST - bit_i)];
    end else if (stage == H_RCOUNT) begin
      drive_low = (cnt != ZERO_BYTE);
    end else begin
      drive_low = (stage == H_RDATA) & ~last;
    end
  end

  // quarter-bit timer; halts in idle so scl stays released
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qtmr <= '0;
    end else if (stage == H_IDLE || qtmr == '0) begin
      qtmr <= QTR_W'(QTR_CNT - 1);
    end else begin
      qtmr <= qtmr - 1'b1;
    end
  end
  assign tick = (stage != H_IDLE) && (qtmr == '0);

  // transfer sequencer: start, bytes with acks, stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage  <= H_IDLE;
      q      <= Q_SETUP;
      bit_i  <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ptr    <= ZERO_BYTE;
      seen   <= ZERO_BYTE;
      rx_sh  <= ZERO_BYTE;
      rd_dir <= 1'b0;
      err    <= 1'b0;
      done   <= 1'b0;
    end else if (stage == H_IDLE) begin
      q     <= Q_SETUP;
      bit_i <= '0;
      if (cmd_wr && cmd_addr == HR_CTRL && cmd_wdata[CTRL_GO]) begin
        rd_dir <= cmd_wdata[CTRL_RD];
        err    <= 1'b0;
        done   <= 1'b0;
        stage  <= H_START;
      end
    end else if (tick) begin
      q <= q + 2'h1;
      if (stage == H_START || stage == H_RSTART) begin
        case (q)
          Q_SETUP:  sda_oe <= 1'b0;
          Q_RISE:   scl_oe <= 1'b0;
          Q_SAMPLE: sda_oe <= 1'b1; // falling sda with scl high
          default: begin
            scl_oe <= 1'b1;
            stage  <= (stage == H_START) ? H_ADDR_W : H_ADDR_R;
          end
        endcase
      end else if (stage == H_STOP) begin
        case (q)
          Q_SETUP:  sda_oe <= 1'b1;
          Q_RISE:   scl_oe <= 1'b0;
          Q_SAMPLE: sda_oe <= 1'b0; // rising sda with scl high
          default: begin
            done  <= 1'b1;
            stage <= H_IDLE;
          end
        endcase
      end else begin
        case (q)
          Q_SETUP:  sda_oe <= drive_low;
          Q_RISE:   scl_oe <= 1'b0;
          Q_SAMPLE: begin
            if (bit_i != BIT_ACK) begin
              rx_sh <= {rx_sh[6:0], bus.sda};
            end
          end
          default: begin
            scl_oe <= 1'b1;
            bit_i  <= (bit_i == BIT_ACK) ? '0 : bit_i + 4'h1;
            if (bit_i == BIT_ACK) begin
              err <= err | (is_tx & bus.sda);
              case (stage)
                H_ADDR_W: stage <= bus.sda ? H_STOP : H_INDEX;
                H_INDEX:  stage <= bus.sda ? H_STOP
                                 : (rd_dir ? H_RSTART : H_COUNT);
                H_COUNT: begin
                  ptr   <= ZERO_BYTE;
                  stage <= (bus.sda || cnt == ZERO_BYTE) ? H_STOP
                                                         : H_WDATA;
                end
                H_WDATA: begin
                  ptr <= ptr + 8'h01;
                  if (bus.sda || last) begin
                    stage <= H_STOP;
                  end
                end
                H_ADDR_R: stage <= bus.sda ? H_STOP : H_RCOUNT;
                H_RCOUNT: begin
                  seen  <= rx_sh;
                  ptr   <= ZERO_BYTE;
                  stage <= (cnt == ZERO_BYTE) ? H_STOP : H_RDATA;
                end
                H_RDATA: begin
                  ptr <= ptr + 8'h01;
                  if (last) begin
                    stage <= H_STOP;
                  end
                end
                default: stage <= H_STOP;
              endcase
            end
          end
        endcase
      end
    end
  end

  // software-set transfer parameters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx   <= ZERO_BYTE;
      cnt   <= ZERO_BYTE;
      taddr <= DEF_TADDR;
    end else if (cmd_wr) begin
      case (cmd_addr)
        HR_INDEX: idx   <= cmd_wdata;
        HR_COUNT: cnt   <= cmd_wdata;
        HR_TADDR: taddr <= cmd_wdata[6:0];
        default:  ;
      endcase
    end
  end

  // data buffer; received bytes win over a software write
  always_ff @(posedge clk_sys) begin
    if (tick && q == Q_FALL && bit_i == BIT_ACK && stage == H_RDATA) begin
      buf_mem[ptr[AW-1:0]] <= rx_sh;
    end else if (cmd_wr && in_buf) begin
      buf_mem[boff[AW-1:0]] <= cmd_wdata;
    end
  end

  // readback mux, answered one cycle after the strobe
  always_comb begin
    case (cmd_addr)
      HR_INDEX:  rd_val = idx;
      HR_COUNT:  rd_val = cnt;
      HR_STATUS: rd_val = {5'h0, done, err, stage != H_IDLE};
      HR_TADDR:  rd_val = {1'b0, taddr};
      HR_RXCNT:  rd_val = seen;
      default:   rd_val = in_buf ? buf_mem[boff[AW-1:0]] : ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= ZERO_BYTE;
    end else begin
      cmd_rdata <= cmd_rd ? rd_val : ZERO_BYTE;
    end
  end

  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
endmodule // scc_host

// ===== scc_pkg.sv
package scc_pkg;
  // target register map, byte index as sent in the index byte
  localparam logic [7:0] REG_OE      = 8'h00;
  localparam logic [7:0] REG_SPREAD  = 8'h01;
  localparam logic [7:0] REG_COUNT   = 8'h07;
  localparam logic [7:0] OE_RST      = 8'hDD;
  localparam logic [7:0] OE_WR_MASK  = 8'hDD;
  localparam logic [7:0] SPR_RST     = 8'h02;
  localparam logic [7:0] SPR_WR_MASK = 8'h3B;
  localparam logic [7:0] SPR_FIXED   = 8'h04;
  localparam logic [7:0] CNT_RST     = 8'h08;
  localparam logic [7:0] CNT_WR_MASK = 8'h1F;
  localparam logic [7:0] IDLE_BYTE   = 8'hFF;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  // field positions inside the spread/amplitude byte
  localparam int SPR_STRAP_LSB = 6;
  localparam int SW_OVR_BIT    = 5;
  localparam int SW_LVL_LSB    = 3;
  localparam int AMP_LSB       = 0;
  // differential outputs and their enable bit positions
  localparam int N_DIFF = 6;
  localparam int OE_POS [N_DIFF] = '{0, 2, 3, 4, 6, 7};
  // tri-level strap codes
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_MID  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  // serial framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [1:0] Q_SETUP  = 2'h0;
  localparam logic [1:0] Q_RISE   = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL   = 2'h3;
  // host controller registers
  localparam logic [7:0] HR_CTRL   = 8'h00;
  localparam logic [7:0] HR_INDEX  = 8'h01;
  localparam logic [7:0] HR_COUNT  = 8'h02;
  localparam logic [7:0] HR_STATUS = 8'h03;
  localparam logic [7:0] HR_TADDR  = 8'h04;
  localparam logic [7:0] HR_RXCNT  = 8'h05;
  localparam logic [7:0] HR_BUF    = 8'h08;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_DONE = 2;
  localparam logic [6:0] DEF_TADDR = 7'h50;
  // timing: scl period, quarter of it in clk_sys cycles (rounded down)
  localparam int CLK_NS        = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int QTR_W         = 16;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_ADDR   = 3'h1,
    PH_INDEX  = 3'h3,
    PH_COUNT  = 3'h2,
    PH_WDATA  = 3'h6,
    PH_RCOUNT = 3'h7,
    PH_RDATA  = 3'h5
  } scc_dphase_t;

  typedef enum logic [3:0] {
    H_IDLE   = 4'h0,
    H_START  = 4'h1,
    H_ADDR_W = 4'h3,
    H_INDEX  = 4'h2,
    H_COUNT  = 4'h6,
    H_WDATA  = 4'h7,
    H_RSTART = 4'h5,
    H_ADDR_R = 4'h4,
    H_RCOUNT = 4'hC,
    H_RDATA  = 4'hD,
    H_STOP   = 4'hF
  } scc_hstage_t;
endpackage

// ===== scc_smbus_if.sv
`timescale 1ns/1ps
interface scc_smbus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wire: released lines float high
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                input scl, sda);
  modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ===== scc_target.sv
`timescale 1ns/1ps
module scc_target #(
  parameter logic [6:0] ADDR_STRAP_LO = 7'h50,
  parameter logic [6:0] ADDR_STRAP_HI = 7'h51
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  scc_smbus_if.dev                          bus,
  input  wire logic                         target_addr_strap,
  input  wire logic [1:0]                   spread_strap_level,
  input  wire logic [scc_pkg::N_DIFF-1:0]   diff_out_enable_n,
  output logic      [scc_pkg::N_DIFF-1:0]   diff_clock_output_run,
  output logic      [1:0]                   spread_sel,
  output logic      [1:0]                   amp_sel
);
  import scc_pkg::*;

  scc_dphase_t phase;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  tx_sh;
  logic [7:0]  tx_next;
  logic [7:0]  rd_byte;
  logic [7:0]  ptr;
  logic [7:0]  left;
  logic        from_addr;
  logic        ack_seen;
  logic        sda_oe;
  logic        straps_done;
  logic [6:0]  my_addr;
  logic [1:0]  strap_lvl;
  logic [7:0]  oe_reg;
  logic [7:0]  spr_reg;
  logic [7:0]  cnt_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        is_tx;
  logic        wr_en;

  // inputs are synchronous; one history flop gives edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign scl_rise  = bus.scl & ~scl_q;
  assign scl_fall  = ~bus.scl & scl_q;
  assign start_det = bus.scl & scl_q & sda_q & ~bus.sda;
  assign stop_det  = bus.scl & scl_q & ~sda_q & bus.sda;
  assign is_tx     = (phase == PH_RCOUNT) || (phase == PH_RDATA);
  assign wr_en     = scl_fall && (bit_cnt == BIT_LAST)
                     && (phase == PH_WDATA);

  // straps caught once after reset release, then held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      straps_done <= 1'b0;
      my_addr     <= ADDR_STRAP_LO;
      strap_lvl   <= STRAP_LOW;
    end else if (!straps_done) begin
      straps_done <= 1'b1;
      my_addr     <= target_addr_strap ? ADDR_STRAP_HI
                                       : ADDR_STRAP_LO;
      strap_lvl   <= spread_strap_level;
    end
  end

  // receive shifter, sampled while scl rises on data bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh <= ZERO_BYTE;
    end else if (scl_rise && bit_cnt != BIT_ACK) begin
      rx_sh <= {rx_sh[6:0], bus.sda};
    end
  end

  // register readback; reserved bits show fixed defaults
  always_comb begin
    case (ptr)
      REG_OE:     rd_byte = oe_reg & OE_WR_MASK;
      REG_SPREAD: rd_byte = (spr_reg & SPR_WR_MASK) | SPR_FIXED
                            | ({6'h0, strap_lvl} << SPR_STRAP_LSB);
      REG_COUNT:  rd_byte = cnt_reg & CNT_WR_MASK;
      default:    rd_byte = ZERO_BYTE;
    endcase
  end

  // next byte to send: count first, then data, then idle ones
  always_comb begin
    if (phase == PH_RCOUNT) begin
      tx_next = cnt_reg;
    end else if (left != ZERO_BYTE) begin
      tx_next = rd_byte;
    end else begin
      tx_next = IDLE_BYTE;
    end
  end

  // writable registers; masks keep reserved bits out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg  <= OE_RST;
      spr_reg <= SPR_RST;
      cnt_reg <= CNT_RST;
    end else if (wr_en) begin
      case (ptr)
        REG_OE:     oe_reg  <= rx_sh & OE_WR_MASK;
        REG_SPREAD: spr_reg <= rx_sh & SPR_WR_MASK;
        REG_COUNT:  cnt_reg <= rx_sh & CNT_WR_MASK;
        default:    ;
      endcase
    end
  end

  // protocol engine; start and stop win over bit events
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= PH_IDLE;
      bit_cnt   <= '0;
      tx_sh     <= IDLE_BYTE;
      ptr       <= ZERO_BYTE;
      left      <= ZERO_BYTE;
      from_addr <= 1'b0;
      ack_seen  <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start_det) begin
      phase   <= PH_ADDR; // repeated start keeps the pointer
      bit_cnt <= BIT_ACK; // the start's own scl fall wraps it to bit 0
      sda_oe  <= 1'b0;
    end else if (stop_det) begin
      phase   <= PH_IDLE;
      bit_cnt <= '0;
      sda_oe  <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt == BIT_ACK) begin
        ack_seen <= ~bus.sda;
      end
    end else if (scl_fall && phase != PH_IDLE) begin
      bit_cnt <= (bit_cnt == BIT_ACK) ? '0 : bit_cnt + 4'h1;
      if (bit_cnt == BIT_LAST) begin
        sda_oe <= 1'b0; // sending phases free the line for the host ack
        case (phase)
          PH_ADDR: begin
            if (rx_sh[7:1] == my_addr) begin
              sda_oe    <= 1'b1;
              from_addr <= 1'b1;
              phase     <= rx_sh[0] ? PH_RCOUNT : PH_INDEX;
            end else begin
              phase <= PH_IDLE; // not ours: stay silent till next start
            end
          end
          PH_INDEX: begin
            sda_oe <= 1'b1;
            ptr    <= rx_sh;
            phase  <= PH_COUNT;
          end
          PH_COUNT: begin
            sda_oe <= 1'b1;
            phase  <= PH_WDATA;
          end
          PH_WDATA: begin
            sda_oe <= 1'b1;
            ptr    <= ptr + 8'h01;
          end
          default: ;
        endcase
      end else if (bit_cnt == BIT_ACK) begin
        sda_oe <= 1'b0;
        if (is_tx) begin
          if (from_addr || ack_seen) begin
            from_addr <= 1'b0;
            sda_oe    <= ~tx_next[7];
            tx_sh     <= {tx_next[6:0], 1'b1};
            if (phase == PH_RCOUNT) begin
              phase <= PH_RDATA;
              left  <= cnt_reg;
            end else if (left != ZERO_BYTE) begin
              ptr  <= ptr + 8'h01;
              left <= left - 8'h01;
            end
          end else begin
            phase <= PH_IDLE; // host nack ends the read
          end
        end
      end else if (is_tx) begin
        sda_oe <= ~tx_sh[7];
        tx_sh  <= {tx_sh[6:0], 1'b1};
      end
    end
  end

  assign bus.dev_sda_oe = sda_oe;
  assign bus.dev_sda_o  = 1'b0;

  // clock gating per output: enable bit and active-low pin
  for (genvar i = 0; i < N_DIFF; i++) begin : g_diff
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        diff_clock_output_run[i] <= 1'b0;
      end else begin
        diff_clock_output_run[i] <= oe_reg[OE_POS[i]]
                                    & ~diff_out_enable_n[i];
      end
    end
  end

  // spread and amplitude controls to the analog side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spread_sel <= STRAP_LOW;
      amp_sel    <= SPR_RST[AMP_LSB +: 2];
    end else begin
      spread_sel <= spr_reg[SW_OVR_BIT] ? spr_reg[SW_LVL_LSB +: 2]
                                        : strap_lvl;
      amp_sel    <= spr_reg[AMP_LSB +: 2];
    end
  end
endmodule // scc_target

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import scc_pkg::*;
  localparam logic [6:0] ADDR_HI = 7'h51; // arbitrary strap-high address
  logic              clk_sys;
  logic              rst_n;
  logic [7:0]        cmd_addr;
  logic [7:0]        cmd_wdata;
  logic              cmd_wr;
  logic              cmd_rd;
  logic [7:0]        cmd_rdata;
  logic              target_addr_strap;
  logic [1:0]        spread_strap_level;
  logic [N_DIFF-1:0] diff_out_enable_n;
  logic [N_DIFF-1:0] diff_clock_output_run;
  logic [1:0]        spread_sel;
  logic [1:0]        amp_sel;
  int                errors;
  int                check_count;
  logic [7:0]        v;
  logic [7:0]        exp_rd [8];

  // short quarters keep each serial byte near 150 clocks
  scc_smbus_if scc_smbus_if_inst ();
  scc_host #(.DEPTH(8), .QTR_CNT(4)) scc_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(scc_smbus_if_inst),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  scc_target #(.ADDR_STRAP_LO(DEF_TADDR), .ADDR_STRAP_HI(ADDR_HI))
  scc_target_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(scc_smbus_if_inst),
    .target_addr_strap(target_addr_strap),
    .spread_strap_level(spread_strap_level),
    .diff_out_enable_n(diff_out_enable_n),
    .diff_clock_output_run(diff_clock_output_run),
    .spread_sel(spread_sel), .amp_sel(amp_sel));
  scc_chk scc_chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .host_scl_oe(scc_smbus_if_inst.host_scl_oe),
    .host_sda_oe(scc_smbus_if_inst.host_sda_oe),
    .dev_sda_oe(scc_smbus_if_inst.dev_sda_oe),
    .scl(scc_smbus_if_inst.scl), .sda(scc_smbus_if_inst.sda));

  // 20 MHz system clock
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    cmd_wr    <= 1'b1;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cmd_rd   <= 1'b1;
    cmd_addr <= a;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask

  // one serial frame; done without err means every ack came back
  task automatic xfer(input logic rdf, input logic [7:0] idx, cnt);
    int i;
    wr(HR_INDEX, idx);
    wr(HR_COUNT, cnt);
    wr(HR_CTRL, {6'h00, rdf, 1'b1});
    for (i = 0; i < 3000; i++) begin
      rd(HR_STATUS, v);
      if (v[ST_DONE] === 1'b1 && v[ST_BUSY] === 1'b0) break;
    end
    if (i == 3000) begin
      errors++;
      give_verdict();
    end
    chk("status", v & 8'h07, 8'h04);
  endtask

  task automatic check_buf(input int n, input string name);
    int i;
    for (i = 0; i < n; i++) begin
      rd(HR_BUF + 8'(i), v);
      chk(name, v, exp_rd[i]);
    end
  endtask

  // the outputs lag the registers and pins by one flop
  task automatic check_out(input logic [5:0] run, input logic [1:0] spr, amp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("run", {2'h0, diff_clock_output_run}, {2'h0, run});
    chk("spread", {6'h00, spread_sel}, {6'h00, spr});
    chk("amp", {6'h00, amp_sel}, {6'h00, amp});
  endtask

  // straps move one clock after the latch edge; the latched copy must not
  task automatic do_reset(input logic strap, input logic [1:0] ss);
    rst_n              <= 1'b0;
    target_addr_strap  <= strap;
    spread_strap_level <= ss;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    target_addr_strap  <= ~strap;
    spread_strap_level <= STRAP_LOW;
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    target_addr_strap = 1'b0;
    spread_strap_level = STRAP_MID;
    diff_out_enable_n = 6'h20;
    do_reset(1'b0, STRAP_MID);
    // reset image: count byte first, then bytes 0..7 ascending
    check_out(6'h1F, STRAP_MID, 2'h2);
    xfer(1'b1, REG_OE, 8'h08);
    rd(HR_RXCNT, v);
    chk("count", v, CNT_RST);
    exp_rd = '{8'hDD, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    check_buf(8, "reset image");
    // reserved bits dropped, two enables left, software spread taken
    wr(HR_BUF, 8'h6A);
    wr(HR_BUF + 8'h01, 8'hF9);
    xfer(1'b0, REG_OE, 8'h02);
    check_out(6'h14, 2'h3, 2'h1);
    xfer(1'b1, REG_OE, 8'h02);
    exp_rd[0] = 8'h48;
    exp_rd[1] = 8'h7D;
    check_buf(2, "written image");
    @(posedge clk_sys);
    diff_out_enable_n <= 6'h00;
    check_out(6'h14, 2'h3, 2'h1);
    @(posedge clk_sys);
    diff_out_enable_n <= 6'h3F;
    check_out(6'h00, 2'h3, 2'h1);
    // spread and amplitude codes 0, 1 and 3 checked under software control
    for (int k = 0; k < 4; k++) begin
      wr(HR_BUF, {2'h0, 1'b1, 2'(k), 1'b0, 2'(k)});
      xfer(1'b0, REG_SPREAD, 8'h01);
      if (k != 2) check_out(6'h00, 2'(k), 2'(k));
    end
    wr(HR_BUF, 8'h19);
    xfer(1'b0, REG_SPREAD, 8'h01);
    check_out(6'h00, STRAP_MID, 2'h1);
    // count field sets the count byte; reserved count bits dropped
    wr(HR_BUF, 8'hE3);
    xfer(1'b0, REG_COUNT, 8'h01);
    xfer(1'b1, REG_SPREAD, 8'h03);
    rd(HR_RXCNT, v);
    chk("count", v, 8'h03);
    exp_rd[0] = 8'h5D;
    exp_rd[1] = 8'h00;
    check_buf(3, "count image");
    xfer(1'b1, REG_COUNT, 8'h01);
    exp_rd[0] = 8'h03;
    check_buf(1, "count byte");
    // second reset with the other address strap and a high spread strap
    do_reset(1'b1, STRAP_HIGH);
    wr(HR_TADDR, {1'b0, ADDR_HI});
    xfer(1'b1, REG_OE, 8'h02);
    exp_rd[0] = OE_RST;
    exp_rd[1] = 8'hC6;
    check_buf(2, "strap image");
    @(posedge clk_sys);
    diff_out_enable_n <= 6'h00;
    check_out(6'h3F, STRAP_HIGH, 2'h2);
    give_verdict();
  end
endmodule // tb
